/* File: hdl/charger_option_pkg.sv */
package charger_option_pkg;
    localparam logic [6:0]  SMB_ADDR        = 7'h09;
    localparam logic [7:0]  CMD_OPTION      = 8'h12;
    localparam logic [7:0]  CMD_CHG_CURRENT = 8'h14;
    localparam logic [7:0]  CMD_CHG_VOLTAGE = 8'h15;
    localparam logic [15:0] OPT_RESET       = 16'hE144;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

    localparam int B_SAVER   = 15;
    localparam int B_WDT_HI  = 14;
    localparam int B_WDT_LO  = 13;
    localparam int B_OVP_THR = 12;
    localparam int B_OVP_ST  = 11;
    localparam int B_AUDIO   = 10;
    localparam int B_FREQ_HI = 9;
    localparam int B_FREQ_LO = 8;
    localparam int B_INOC    = 7;
    localparam int B_LSW     = 6;
    localparam int B_CALIB   = 5;
    localparam int B_MONSEL  = 4;
    localparam int B_OVRD    = 3;
    localparam int B_LDO     = 2;
    localparam int B_PWRMGT  = 1;
    localparam int B_INHIBIT = 0;

    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] WDT_44  = 2'h1;
    localparam logic [1:0] WDT_88  = 2'h2;
    localparam logic [1:0] WDT_175 = 2'h3;

    localparam logic [1:0] FREQ_600 = 2'h0;
    localparam logic [1:0] FREQ_800 = 2'h1;
    localparam logic [1:0] FREQ_1M  = 2'h2;
    localparam logic [1:0] FREQ_ALT = 2'h3;

    localparam longint CLK_HZ     = 10_000_000;
    localparam longint WDT_T44_S  = 44;
    localparam longint WDT_T88_S  = 88;
    localparam longint WDT_T175_S = 175;
    localparam logic [31:0] WDT_CYC_44  = 32'(WDT_T44_S * CLK_HZ);
    localparam logic [31:0] WDT_CYC_88  = 32'(WDT_T88_S * CLK_HZ);
    localparam logic [31:0] WDT_CYC_175 = 32'(WDT_T175_S * CLK_HZ);

    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_CMD  = 2'h1;
    localparam logic [1:0] IDX_LO   = 2'h2;
    localparam logic [1:0] IDX_HI   = 2'h3;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_SKIP} smb_state_t;
endpackage

/* File: hdl/charger_option_control_register.sv */
// Notes on behaviour
// - Option word writes at command 0x12 update the option fields anytime.
// - Enabled watchdog with no charge write in period suspends charging.
// - A charge voltage or current write resumes suspended charging.
// - Bit 12 picks over-voltage threshold; detection latches the converter off.
// - Bit 11 shows the over-voltage latch; only writing 0 clears it.
// - Bit 10 forces a 40 kHz minimum switching frequency.
// - Bits 9:8 pick 600 kHz, 800 kHz, 1 MHz, 800 kHz.
// - Bit 7 enables input over-current protection at 333 percent.
// - Bit 6 picks 250 mV or 350 mV low-side switch limit.
// - Bit 5 enters calibration: buck off, battery switch on.
// - Bit 3 chooses automatic or host-chosen monitor output selection.
// - With bit 3 set, bit 4 picks 40x adapter or 16x discharge.
// - With bit 3 clear, bit 4 reads back the automatic selection.
// - Bit 2 set enables LDO precharge; clear turns battery switch on.
// - Bit 1 enables input power management.
// - Bit 0 inhibits charging.
// - Bit 15 quiescent saver acts only while on battery power.
// - Words move over write-word and read-word, low byte first.
module charger_option_control_register #(
    parameter logic [31:0] WDT_CYC_44_P  = charger_option_pkg::WDT_CYC_44,
    parameter logic [31:0] WDT_CYC_88_P  = charger_option_pkg::WDT_CYC_88,
    parameter logic [31:0] WDT_CYC_175_P = charger_option_pkg::WDT_CYC_175
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       smb_clk_i,
    input  wire logic       smb_scl_i,
    input  wire logic       smb_sda_i,
    output logic            smb_sda_o,
    output logic            smb_sda_oe_o,
    input  wire logic       sys_ovp_detect_i,
    input  wire logic       adapter_detect_low_i,
    input  wire logic       supply_uvlo_i,
    output logic            charge_enable_o,
    output logic            charge_suspended_o,
    output logic            converter_latch_off_o,
    output logic            sys_ovp_high_thresh_o,
    output logic            min_freq_40k_o,
    output logic [1:0]      switch_freq_o,
    output logic            input_overcurrent_protect_o,
    output logic            low_side_switch_350mv_o,
    output logic            battery_discharge_calibration_mode_o,
    output logic            buck_enable_o,
    output logic            battery_switch_on_o,
    output logic            ldo_precharge_o,
    output logic            input_power_mgmt_enable_o,
    output logic            current_monitor_output_o,
    output logic            battery_quiescent_saver_o
);
    import charger_option_pkg::*;

    // Core domain
    logic [15:0] opt_r, opt_nxt, rb_word, pub_data_r, pub_data_nxt;
    logic [31:0] wdt_cnt_r, wdt_cnt_nxt, wdt_limit;
    logic        susp_r, susp_nxt, pub_tgl_r, pub_tgl_nxt;
    logic [2:0]  wr_sync_r, ack_sync_r;
    logic        wr_seen_r, wr_seen_nxt, wr_new, wr_opt, wr_chg, period_chg;
    // Link domain
    logic [2:0]  scl_sync_r, sda_sync_r, pub_sync_r;
    logic        scl_r, sda_r, scl_f, sda_f, start, stop, rise, fall;
    logic [15:0] rd_copy_r, rd_copy_nxt, wr_data_r, wr_data_nxt;
    logic [7:0]  wr_cmd_r, wr_cmd_nxt, sh_r, sh_nxt, cmd_r, cmd_nxt, lo_r, lo_nxt;
    logic        seen_r, seen_nxt, wr_tgl_r, wr_tgl_nxt, rd_r, rd_nxt, tx_hi_r, tx_hi_nxt;
    logic [3:0]  bitcnt_r, bitcnt_nxt;
    logic [1:0]  idx_r, idx_nxt;
    smb_state_t  st_r, st_nxt;

    // Write events from the link arrive as a toggle; the word is stable by then
    assign wr_new     = (wr_sync_r[1] == wr_sync_r[2]) && (wr_sync_r[2] != wr_seen_r);
    assign wr_opt     = wr_new && (wr_cmd_r == CMD_OPTION);
    assign wr_chg     = wr_new && (wr_cmd_r == CMD_CHG_CURRENT || wr_cmd_r == CMD_CHG_VOLTAGE);
    assign period_chg = wr_opt && (wr_data_r[B_WDT_HI:B_WDT_LO] != opt_r[B_WDT_HI:B_WDT_LO]);

    always_comb begin
        opt_nxt     = opt_r;
        wr_seen_nxt = wr_new ? wr_sync_r[2] : wr_seen_r;
        if (wr_opt) begin
            opt_nxt           = wr_data_r;
            opt_nxt[B_OVP_ST] = opt_r[B_OVP_ST] & wr_data_r[B_OVP_ST];
        end
        if (sys_ovp_detect_i) begin
            opt_nxt[B_OVP_ST] = 1'b1;
        end
    end

    always_comb begin
        unique case (opt_r[B_WDT_HI:B_WDT_LO])
            WDT_OFF: wdt_limit = WDT_CYC_175_P;
            WDT_44:  wdt_limit = WDT_CYC_44_P;
            WDT_88:  wdt_limit = WDT_CYC_88_P;
            WDT_175: wdt_limit = WDT_CYC_175_P;
        endcase
        wdt_cnt_nxt = wdt_cnt_r + 32'h1;
        susp_nxt    = susp_r;
        if (wr_chg || period_chg || opt_r[B_WDT_HI:B_WDT_LO] == WDT_OFF) begin
            wdt_cnt_nxt = '0;
        end else if (wdt_cnt_r >= wdt_limit - 32'h1) begin
            wdt_cnt_nxt = '0;
            susp_nxt    = 1'b1;
        end
        if (wr_chg) begin
            susp_nxt = 1'b0;
        end
    end

    always_comb begin
        rb_word           = opt_r;
        rb_word[B_MONSEL] = current_monitor_output_o;
        pub_data_nxt      = pub_data_r;
        pub_tgl_nxt       = pub_tgl_r;
        if (ack_sync_r[1] == ack_sync_r[2] && ack_sync_r[2] == pub_tgl_r
            && rb_word != pub_data_r) begin
            pub_data_nxt = rb_word;
            pub_tgl_nxt  = ~pub_tgl_r;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opt_r      <= OPT_RESET;
            wdt_cnt_r  <= '0;
            susp_r     <= 1'b0;
            wr_sync_r  <= '0;
            ack_sync_r <= '0;
            wr_seen_r  <= 1'b0;
            pub_data_r <= OPT_RESET;
            pub_tgl_r  <= 1'b0;
        end else begin
            opt_r      <= opt_nxt;
            wdt_cnt_r  <= wdt_cnt_nxt;
            susp_r     <= susp_nxt;
            wr_sync_r  <= {wr_sync_r[1:0], wr_tgl_r};
            ack_sync_r <= {ack_sync_r[1:0], seen_r};
            wr_seen_r  <= wr_seen_nxt;
            pub_data_r <= pub_data_nxt;
            pub_tgl_r  <= pub_tgl_nxt;
        end
    end

    assign charge_suspended_o    = susp_r;
    assign converter_latch_off_o = opt_r[B_OVP_ST];
    assign charge_enable_o       = !opt_r[B_INHIBIT] && !susp_r && !opt_r[B_OVP_ST]
                                   && !opt_r[B_CALIB];
    assign sys_ovp_high_thresh_o = opt_r[B_OVP_THR];
    assign min_freq_40k_o        = opt_r[B_AUDIO];
    assign switch_freq_o         = (opt_r[B_FREQ_HI:B_FREQ_LO] == FREQ_ALT) ? FREQ_800
                                   : opt_r[B_FREQ_HI:B_FREQ_LO];
    assign input_overcurrent_protect_o = opt_r[B_INOC];
    assign low_side_switch_350mv_o     = opt_r[B_LSW];
    assign battery_discharge_calibration_mode_o = opt_r[B_CALIB];
    assign buck_enable_o         = !opt_r[B_CALIB] && !opt_r[B_OVP_ST];
    assign battery_switch_on_o   = opt_r[B_CALIB] || !opt_r[B_LDO];
    assign ldo_precharge_o       = opt_r[B_LDO];
    assign input_power_mgmt_enable_o = opt_r[B_PWRMGT];
    assign current_monitor_output_o  = opt_r[B_OVRD] ? opt_r[B_MONSEL]
                                       : opt_r[B_PWRMGT];
    assign battery_quiescent_saver_o = opt_r[B_SAVER]
                                       && (adapter_detect_low_i || supply_uvlo_i);

    // Link domain: pins filtered by three flops, change taken when last two agree
    assign scl_f = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_r;
    assign sda_f = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_r;
    assign start = scl_r && scl_f && sda_r && !sda_f;
    assign stop  = scl_r && scl_f && !sda_r && sda_f;
    assign rise  = !scl_r && scl_f;
    assign fall  = scl_r && !scl_f;
    assign smb_sda_o    = 1'b0;
    assign smb_sda_oe_o = (st_r == ST_RX_ACK) || (st_r == ST_TX && !sh_r[7]);

    always_comb begin
        st_nxt      = st_r;
        sh_nxt      = sh_r;
        bitcnt_nxt  = bitcnt_r;
        idx_nxt     = idx_r;
        rd_nxt      = rd_r;
        cmd_nxt     = cmd_r;
        lo_nxt      = lo_r;
        tx_hi_nxt   = tx_hi_r;
        wr_cmd_nxt  = wr_cmd_r;
        wr_data_nxt = wr_data_r;
        wr_tgl_nxt  = wr_tgl_r;
        rd_copy_nxt = rd_copy_r;
        seen_nxt    = seen_r;
        if (pub_sync_r[1] == pub_sync_r[2] && pub_sync_r[2] != seen_r) begin
            rd_copy_nxt = pub_data_r;
            seen_nxt    = pub_sync_r[2];
        end
        if (start) begin
            st_nxt     = ST_RX;
            bitcnt_nxt = '0;
            idx_nxt    = IDX_ADDR;
        end else if (stop) begin
            st_nxt = ST_IDLE;
        end else begin
            unique case (st_r)
                ST_IDLE, ST_SKIP: begin
                end
                ST_RX: begin
                    if (rise) begin
                        sh_nxt     = {sh_r[6:0], sda_f};
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end else if (fall && bitcnt_r == BITS_PER_BYTE) begin
                        st_nxt = (idx_r == IDX_ADDR && sh_r[7:1] != SMB_ADDR) ? ST_SKIP
                                 : ST_RX_ACK;
                        if (idx_r == IDX_ADDR) rd_nxt = sh_r[0];
                        if (idx_r == IDX_CMD) cmd_nxt = sh_r;
                        if (idx_r == IDX_LO) lo_nxt = sh_r;
                        if (idx_r == IDX_HI) begin
                            wr_cmd_nxt  = cmd_r;
                            wr_data_nxt = {sh_r, lo_r};
                            wr_tgl_nxt  = ~wr_tgl_r;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (fall) begin
                        bitcnt_nxt = '0;
                        if (idx_r == IDX_ADDR && rd_r) begin
                            st_nxt    = ST_TX;
                            tx_hi_nxt = 1'b0;
                            sh_nxt    = (cmd_r == CMD_OPTION) ? rd_copy_r[7:0] : BYTE_ZERO;
                            lo_nxt    = (cmd_r == CMD_OPTION) ? rd_copy_r[15:8] : BYTE_ZERO;
                        end else begin
                            st_nxt  = (idx_r == IDX_HI) ? ST_SKIP : ST_RX;
                            idx_nxt = idx_r + 2'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (fall) begin
                        sh_nxt     = {sh_r[6:0], 1'b0};
                        bitcnt_nxt = bitcnt_r + 4'h1;
                        if (bitcnt_r == BITS_PER_BYTE - 4'h1) st_nxt = ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (rise && (sda_f || tx_hi_r)) begin
                        st_nxt = ST_SKIP;
                    end else if (fall) begin
                        st_nxt     = ST_TX;
                        bitcnt_nxt = '0;
                        tx_hi_nxt  = 1'b1;
                        sh_nxt     = lo_r;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge smb_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            pub_sync_r <= '0;
            scl_r      <= 1'b1;
            sda_r      <= 1'b1;
            st_r       <= ST_IDLE;
            sh_r       <= '0;
            bitcnt_r   <= '0;
            idx_r      <= IDX_ADDR;
            rd_r       <= 1'b0;
            cmd_r      <= '0;
            lo_r       <= '0;
            tx_hi_r    <= 1'b0;
            wr_cmd_r   <= '0;
            wr_data_r  <= '0;
            wr_tgl_r   <= 1'b0;
            rd_copy_r  <= OPT_RESET;
            seen_r     <= 1'b0;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], smb_scl_i};
            sda_sync_r <= {sda_sync_r[1:0], smb_sda_i};
            pub_sync_r <= {pub_sync_r[1:0], pub_tgl_r};
            scl_r      <= scl_f;
            sda_r      <= sda_f;
            st_r       <= st_nxt;
            sh_r       <= sh_nxt;
            bitcnt_r   <= bitcnt_nxt;
            idx_r      <= idx_nxt;
            rd_r       <= rd_nxt;
            cmd_r      <= cmd_nxt;
            lo_r       <= lo_nxt;
            tx_hi_r    <= tx_hi_nxt;
            wr_cmd_r   <= wr_cmd_nxt;
            wr_data_r  <= wr_data_nxt;
            wr_tgl_r   <= wr_tgl_nxt;
            rd_copy_r  <= rd_copy_nxt;
            seen_r     <= seen_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    ovp_set_a: assert property (sys_ovp_detect_i |=> opt_r[B_OVP_ST] && !buck_enable_o)
        else $error("over-voltage latch not set");
    ovp_hold_a: assert property (opt_r[B_OVP_ST] && !wr_opt |=> opt_r[B_OVP_ST])
        else $error("over-voltage latch dropped without write");
    wdt_expire_a: assert property (opt_r[B_WDT_HI:B_WDT_LO] != WDT_OFF
        && !wr_chg && !period_chg && wdt_cnt_r == wdt_limit - 32'h1
        |=> susp_r && !charge_enable_o)
        else $error("watchdog expiry did not suspend");
    wdt_resume_a: assert property (wr_chg |=> !susp_r && wdt_cnt_r == '0)
        else $error("charge write did not resume");
    wdt_off_a: assert property (opt_r[B_WDT_HI:B_WDT_LO] == WDT_OFF && !susp_r
        |=> !susp_r)
        else $error("disabled watchdog suspended charging");
    opt_write_a: assert property (wr_opt |=> opt_r[B_AUDIO:B_INHIBIT]
        == {$past(wr_data_r[B_AUDIO:B_FREQ_LO]), $past(wr_data_r[B_INOC:B_INHIBIT])})
        else $error("option write not stored");
    mon_sel_a: assert property (!opt_r[B_OVRD] |-> rb_word[B_MONSEL] == opt_r[B_PWRMGT])
        else $error("monitor readback wrong");
    freq_a: assert property (opt_r[B_FREQ_HI:B_FREQ_LO] == FREQ_ALT
        |-> switch_freq_o == FREQ_800)
        else $error("frequency decode wrong");
    inhibit_a: assert property (opt_r[B_INHIBIT] |-> !charge_enable_o)
        else $error("charge not inhibited");
    saver_a: assert property (battery_quiescent_saver_o
        |-> adapter_detect_low_i || supply_uvlo_i)
        else $error("saver active on adapter power");
    ack_drive_a: assert property (@(posedge smb_clk_i) disable iff (!rstn_i)
        st_r == ST_RX && fall && bitcnt_r == BITS_PER_BYTE && idx_r != IDX_ADDR
        |=> smb_sda_oe_o)
        else $error("acknowledge not driven");

    expire_c: cover property (!susp_r ##1 susp_r);
    ovp_c:    cover property (opt_r[B_OVP_ST] && wr_opt ##1 !opt_r[B_OVP_ST]);
    write_c:  cover property (wr_opt);
    read_c:   cover property (@(posedge smb_clk_i) disable iff (!rstn_i) st_r == ST_TX && tx_hi_r);
endmodule // charger_option_control_register

/* File: tb/smbus_host_model.sv */
module smbus_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import charger_option_pkg::*;

    initial begin
        scl_o    = 1'h1;
        sda_oe_o = 1'h0;
    end

    // Data moves while SCL is low, both sides sample while SCL is high
    task automatic xbit(input logic b, output logic r);
        sda_oe_o <= ~b;
        @(posedge clk_i);
        scl_o <= 1'h1;
        @(posedge clk_i);
        @(posedge clk_i);
        r = sda_i;
        scl_o <= 1'h0;
        @(posedge clk_i);
    endtask

    // MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic n);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(a, n);
    endtask

    task automatic start();
        sda_oe_o <= 1'h0;
        @(posedge clk_i);
        scl_o <= 1'h1;
        @(posedge clk_i);
        sda_oe_o <= 1'h1;
        @(posedge clk_i);
        scl_o <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic stop();
        sda_oe_o <= 1'h1;
        @(posedge clk_i);
        scl_o <= 1'h1;
        @(posedge clk_i);
        sda_oe_o <= 1'h0;
        @(posedge clk_i);
        @(posedge clk_i);
    endtask

    // Low byte before high byte
    task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                              input logic [15:0] data, output logic nak);
        logic [7:0] q;
        logic       n0, n1, n2, n3;
        start();
        xbyte({addr, 1'h0}, 1'h1, q, n0);
        xbyte(cmd, 1'h1, q, n1);
        xbyte(data[7:0], 1'h1, q, n2);
        xbyte(data[15:8], 1'h1, q, n3);
        stop();
        nak = n0 | n1 | n2 | n3;
    endtask

    task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                             output logic nak);
        logic [7:0] q;
        logic       n0, n1, n2, n3;
        start();
        xbyte({SMB_ADDR, 1'h0}, 1'h1, q, n0);
        xbyte(cmd, 1'h1, q, n1);
        start();
        xbyte({SMB_ADDR, 1'h1}, 1'h1, q, n2);
        xbyte(8'hFF, 1'h0, data[7:0], n3);
        xbyte(8'hFF, 1'h1, data[15:8], n3);
        stop();
        nak = n0 | n1 | n2;
    endtask
endmodule // smbus_host_model

/* File: tb/charger_option_control_register_tb_top.sv */
module charger_option_control_register_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import charger_option_pkg::*;

    localparam logic [31:0] CYC44 = 32'h32, CYC88 = 32'h64, CYC175 = 32'hC8;
    logic clk_i = 1'h0, smb_clk_i = 1'h0, rstn_i = 1'h0, host_oe;
    logic sys_ovp_detect_i = 1'h0, adapter_detect_low_i = 1'h0, supply_uvlo_i = 1'h0;
    logic smb_scl_i, smb_sda_i, smb_sda_o, smb_sda_oe_o, charge_enable_o, charge_suspended_o;
    logic converter_latch_off_o, sys_ovp_high_thresh_o, min_freq_40k_o, ldo_precharge_o;
    logic input_overcurrent_protect_o, low_side_switch_350mv_o, buck_enable_o;
    logic battery_discharge_calibration_mode_o, battery_switch_on_o, current_monitor_output_o;
    logic input_power_mgmt_enable_o, battery_quiescent_saver_o, nak;
    logic [1:0]  switch_freq_o;
    logic [15:0] rd, d;
    integer errors = 0, n_compared = 0, seed = 32'hCE99, opt, ovp, susp;
    int lims[3] = '{50, 100, 200};

    // Open-drain wire with pull-up
    assign smb_sda_i = ~((smb_sda_oe_o & ~smb_sda_o) | host_oe);

    always #50 clk_i = ~clk_i;
    initial begin
        #3.3;
        forever #6 smb_clk_i = ~smb_clk_i;
    end

    charger_option_control_register #(.WDT_CYC_44_P(CYC44), .WDT_CYC_88_P(CYC88),
        .WDT_CYC_175_P(CYC175)) charger_option_control_register_inst (
        .clk_i, .rstn_i, .smb_clk_i, .smb_scl_i, .smb_sda_i, .smb_sda_o, .smb_sda_oe_o,
        .sys_ovp_detect_i, .adapter_detect_low_i, .supply_uvlo_i, .charge_enable_o,
        .charge_suspended_o, .converter_latch_off_o, .sys_ovp_high_thresh_o, .min_freq_40k_o,
        .switch_freq_o, .input_overcurrent_protect_o, .low_side_switch_350mv_o,
        .battery_discharge_calibration_mode_o, .buck_enable_o, .battery_switch_on_o,
        .ldo_precharge_o, .input_power_mgmt_enable_o, .current_monitor_output_o,
        .battery_quiescent_saver_o);

    smbus_host_model smbus_host_model_inst (.clk_i, .sda_i(smb_sda_i), .scl_o(smb_scl_i),
        .sda_oe_o(host_oe));

    function automatic logic [15:0] model_read();
        logic [15:0] v;
        v = opt[15:0];
        v[B_OVP_ST] = ovp[0];
        v[B_MONSEL] = v[B_OVRD] ? v[B_MONSEL] : v[B_PWRMGT];
        return v;
    endfunction

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_outs();
        logic [15:0] e, g;
        logic [15:0] o;
        @(negedge clk_i);
        o = opt[15:0];
        e = {~o[0] & ~susp[0] & ~ovp[0] & ~o[5], susp[0], ovp[0], o[12], o[10],
             (o[9:8] == 2'h3) ? 2'h1 : o[9:8], o[7], o[6], o[5], ~o[5] & ~ovp[0],
             o[5] | ~o[2], o[2], o[1], o[3] ? o[4] : o[1],
             o[15] & (adapter_detect_low_i | supply_uvlo_i)};
        g = {charge_enable_o, charge_suspended_o, converter_latch_off_o, sys_ovp_high_thresh_o,
             min_freq_40k_o, switch_freq_o, input_overcurrent_protect_o, low_side_switch_350mv_o,
             battery_discharge_calibration_mode_o, buck_enable_o, battery_switch_on_o,
             ldo_precharge_o, input_power_mgmt_enable_o, current_monitor_output_o,
             battery_quiescent_saver_o};
        cmp("outs hi", 32'(e[15:8]), 32'(g[15:8]));
        cmp("outs mid", 32'(e[7:4]), 32'(g[7:4]));
        cmp("outs lo", 32'(e[3:0]), 32'(g[3:0]));
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
        smbus_host_model_inst.write_word(SMB_ADDR, cmd, v, nak);
        cmp("write ack", 32'h0, 32'(nak));
        if (cmd == CMD_OPTION) begin
            ovp = ovp & v[B_OVP_ST];
            opt = v;
        end else begin
            susp = 0;
        end
        repeat (8) @(posedge clk_i);
        check_outs();
    endtask

    task automatic rd_chk(input logic [15:0] exp);
        smbus_host_model_inst.read_word(CMD_OPTION, rd, nak);
        cmp("read ack", 32'h0, 32'(nak));
        cmp("read word", 32'(exp), 32'(rd));
    endtask

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole sequence needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        end_of_test();
    end

    initial begin
        opt  = OPT_RESET;
        ovp  = 0;
        susp = 0;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        check_outs();
        rd_chk(OPT_RESET);
        // The 175 s period (scaled) runs out before this write commits
        susp = 1;
        wr(CMD_OPTION, 16'h0144);
        wr(CMD_CHG_VOLTAGE, 16'h3000);
        repeat (6) begin
            d = 16'($random(seed));
            d[B_WDT_HI:B_WDT_LO] = WDT_OFF;
            adapter_detect_low_i <= 1'($random(seed));
            supply_uvlo_i <= 1'($random(seed));
            wr(CMD_OPTION, d);
            rd_chk(model_read());
        end
        for (int f = 0; f < 4; f++) begin
            wr(CMD_OPTION, {6'h00, 2'(f), 3'h0, 1'(f), 4'h8});
            rd_chk(model_read());
        end
        smbus_host_model_inst.write_word(7'h0A, CMD_OPTION, 16'hFFFF, nak);
        cmp("foreign address ack", 32'h1, 32'(nak));
        smbus_host_model_inst.read_word(CMD_CHG_CURRENT, rd, nak);
        cmp("other read ack", 32'h0, 32'(nak));
        cmp("other read word", 32'h0, 32'(rd));
        rd_chk(model_read());
        sys_ovp_detect_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        sys_ovp_detect_i <= 1'h0;
        ovp = 1;
        check_outs();
        wr(CMD_OPTION, model_read() | 16'h0800);
        rd_chk(model_read());
        wr(CMD_OPTION, model_read() & 16'hF7FF);
        rd_chk(model_read());
        for (int p = 1; p < 4; p++) begin
            wr(CMD_OPTION, 16'h0144 | 16'(p << 13));
            wr(CMD_CHG_CURRENT, 16'h0400);
            repeat (lims[p - 1] - 20) @(posedge clk_i);
            check_outs();
            repeat (16) @(posedge clk_i);
            susp = 1;
            check_outs();
        end
        wr(CMD_CHG_VOLTAGE, 16'h3000);
        end_of_test();
    end
endmodule // charger_option_control_register_tb_top
